// ==== ext_bus_params.svh ====
// constants for the external memory bus port
// assumes inclusion by the modules that need timings
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH
`define OSC_PER_STROBE 6
`define RESET_HOLD_CYCLES 24
`define INT_CODE_LAST 16'h1fff
`define STROBE_CNT_W 3
`define LATCH_PHASES 2
`define RST_CNT_W 5
`endif

// ==== ext_bus_pkg.sv ====
// types shared by the external memory bus port
// assumes ext_bus_params.svh is on the include path
package ext_bus_pkg;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ADDR  = 6'h02,
        ST_FETCH = 6'h04,
        ST_RDATA = 6'h08,
        ST_WDATA = 6'h10,
        ST_DONE  = 6'h20
    } bus_state_t;
    typedef struct packed {
        logic        valid;
        logic        is_data;
        logic        is_write;
        logic        wide;
        logic [23:0] addr;
        logic [7:0]  wdata;
    } bus_req_t;
    typedef struct packed {
        logic       done;
        logic [7:0] rdata;
    } bus_rsp_t;
endpackage

// ==== ext_bus_properties.sv ====
// concurrent checks on the pins and strobes of the external memory bus port
// assumes one clock domain and a bind to every external_memory_bus_port
`timescale 1ns/1ps
module ext_bus_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reset_pin,
    input ext_bus_pkg::bus_req_t i_req,
    input wire logic o_code_internal,
    input wire logic o_dev_reset,
    input wire logic [7:0] o_low_address_data_port,
    input wire logic [7:0] o_low_address_data_port_oe_n,
    input wire logic [7:0] o_high_address_port,
    input wire logic o_program_fetch_strobe_n,
    input wire logic o_address_latch_strobe,
    input wire logic o_read_strobe_n,
    input wire logic o_write_strobe_n
);
    import ext_bus_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ============================================================
    // strobes and bus
    property p_ovl; o_read_strobe_n | o_write_strobe_n; endproperty
    a_ovl: assert property (p_ovl) else $error("read and write together");
    property p_fovl; !o_program_fetch_strobe_n |-> o_read_strobe_n & o_write_strobe_n; endproperty
    a_fovl: assert property (p_fovl) else $error("fetch overlaps data");
    property p_wr; !o_write_strobe_n |->
        o_low_address_data_port_oe_n == 8'h00 && o_low_address_data_port == i_req.wdata; endproperty
    a_wr: assert property (p_wr) else $error("write data not driven");
    property p_rd; $fell(o_read_strobe_n) |->
        (!o_read_strobe_n && o_low_address_data_port_oe_n == 8'hff)[*4] ##1 o_read_strobe_n;
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe window wrong");
    property p_fs; $fell(o_program_fetch_strobe_n) |->
        (!o_program_fetch_strobe_n)[*4] ##1 o_program_fetch_strobe_n; endproperty
    a_fs: assert property (p_fs) else $error("fetch strobe width wrong");
    property p_hi; !o_program_fetch_strobe_n |-> o_high_address_port == i_req.addr[15:8];
    endproperty
    a_hi: assert property (p_hi) else $error("code high byte wrong");
    property p_int; o_code_internal |-> o_program_fetch_strobe_n; endproperty
    a_int: assert property (p_int) else $error("strobe on internal fetch");
    // only a driven port is an address phase: idle latch values keep some bits released
    property p_ale; $fell(o_address_latch_strobe) && o_low_address_data_port_oe_n == 8'h00 |->
        $stable(o_low_address_data_port) && o_low_address_data_port == i_req.addr[7:0];
    endproperty
    a_ale: assert property (p_ale) else $error("address moved at latch");
    property p_rst; $rose(o_dev_reset) |-> $past(i_reset_pin, 23) && $past(i_reset_pin);
    endproperty
    a_rst: assert property (p_rst) else $error("reset qualified too soon");
endmodule
bind external_memory_bus_port ext_bus_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_reset_pin(i_reset_pin), .i_req(i_req), .o_code_internal(o_code_internal),
    .o_dev_reset(o_dev_reset), .o_low_address_data_port(o_low_address_data_port),
    .o_low_address_data_port_oe_n(o_low_address_data_port_oe_n),
    .o_high_address_port(o_high_address_port),
    .o_program_fetch_strobe_n(o_program_fetch_strobe_n),
    .o_address_latch_strobe(o_address_latch_strobe), .o_read_strobe_n(o_read_strobe_n),
    .o_write_strobe_n(o_write_strobe_n));

// ==== ext_mem_model.sv ====
// external address latch plus program and data memory
// assumes strobes are registered to i_clk; no wait states on this bus
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic i_clk,
    input wire logic [7:0] i_low_bus,
    input wire logic [7:0] i_high,
    input wire logic i_ale,
    input wire logic i_fetch_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    output logic o_drive,
    output logic [7:0] o_data,
    output logic [23:0] o_wr_addr,
    output logic [7:0] o_wr_data
);
    logic [7:0] lo_r = 8'h00;
    logic [7:0] page_r = 8'h00;
    // ============================================================
    // latch and memory
    always @(negedge i_ale) begin
        lo_r <= i_low_bus;
        page_r <= i_high;
    end
    // contents are a hash of the low and high address bytes, so a wrong one shows as wrong data
    assign o_drive = !i_rd_n || !i_fetch_n;
    assign o_data = lo_r ^ i_high ^ 8'h5a;
    always @(posedge i_clk) begin
        if (!i_wr_n) begin
            o_wr_addr <= {page_r, i_high, lo_r};
            o_wr_data <= i_low_bus;
        end
    end
endmodule

// ==== external_memory_bus_port.sv ====
// external memory bus port: multiplexed low address/data, high address, strobes
// assumes the core supplies one request at a time and holds it until done
// What this block does
// - write strobe low while write data driven
// - read strobe low, memory drives low port
// - code fetch drives address high byte
// - wide data access puts middle/high bytes out
// - fetch strobe once per code access, not data
// - fetch strobe high during internal execution
// - fetch strobe held low at reset: download
// - latch strobe captures low and page byte
// - latch strobe once per external access, data included
// - select high: internal code below 2000h
// - select low: all code fetched externally
// - low port open drain, ones float
// - low port multiplexes address then data
// - bus ones driven strongly on low port
// - high port ones weakly pulled high
// - reset needs 24 cycles high
`timescale 1ns/1ps
`include "ext_bus_params.svh"
module external_memory_bus_port (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reset_pin,
    input wire logic i_external_fetch_select_n,
    input ext_bus_pkg::bus_req_t i_req,
    output ext_bus_pkg::bus_rsp_t o_rsp,
    output logic o_code_internal,
    output logic o_dev_reset,
    output logic o_download_mode,
    input wire logic [7:0] i_port0_out,
    input wire logic [7:0] i_port2_out,
    input wire logic [7:0] i_low_address_data_port,
    output logic [7:0] o_low_address_data_port,
    output logic [7:0] o_low_address_data_port_oe_n,
    input wire logic [7:0] i_high_address_port,
    output logic [7:0] o_high_address_port,
    output logic [7:0] o_high_address_port_oe_n,
    output logic [7:0] o_high_address_port_pullup,
    input wire logic i_program_fetch_strobe_n,
    output logic o_program_fetch_strobe_n,
    output logic o_program_fetch_strobe_n_oe_n,
    output logic o_address_latch_strobe,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n
);
    import ext_bus_pkg::*;
    // ==========================================================
    // reset qualification and strap capture
    logic dev_reset;
    logic dev_reset_d_r;
    reset_filter u_reset_filter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_reset_pin(i_reset_pin),
        .o_dev_reset(dev_reset)
    );
    assign o_dev_reset = dev_reset;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dev_reset_d_r <= 1'b1;
        end else begin
            dev_reset_d_r <= dev_reset;
        end
    end
    // strap sampled on reset release; the pin stays released one cycle past reset,
    // otherwise the sample would see our own idle-high drive instead of the strap
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_download_mode <= 1'b0;
        end else if (dev_reset_d_r && !dev_reset) begin
            o_download_mode <= !i_program_fetch_strobe_n;
        end
    end
    // ==========================================================
    // code space select
    logic ext_code;
    assign ext_code = !i_external_fetch_select_n || (i_req.addr[15:0] > `INT_CODE_LAST);
    assign o_code_internal = i_req.valid && !i_req.is_data && !ext_code;
    // ==========================================================
    // six-period strobe divider
    logic [`STROBE_CNT_W-1:0] ph_r;
    logic ph_tick;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph_r <= '0;
        end else if (dev_reset || ph_tick) begin
            ph_r <= '0;
        end else begin
            ph_r <= ph_r + `STROBE_CNT_W'(1);
        end
    end
    assign ph_tick = (ph_r == `STROBE_CNT_W'(`OSC_PER_STROBE - 1));
    // ==========================================================
    // bus sequencer: one phase per six-period slot, except done which lasts one cycle
    bus_state_t state_r;
    bus_state_t state_nxt;
    bus_req_t cur_r;
    logic ext_active;
    assign ext_active = i_req.valid && (i_req.is_data || ext_code);
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (ext_active) begin
                    state_nxt = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (!cur_r.is_data) begin
                    state_nxt = ST_FETCH;
                end else if (cur_r.is_write) begin
                    state_nxt = ST_WDATA;
                end else begin
                    state_nxt = ST_RDATA;
                end
            end
            ST_FETCH: state_nxt = ST_DONE;
            ST_RDATA: state_nxt = ST_DONE;
            ST_WDATA: state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;
        end else if (dev_reset) begin
            state_r <= ST_IDLE;
        end else if (ph_tick || state_r == ST_DONE) begin
            state_r <= state_nxt;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_r <= '0;
        end else if (state_r == ST_IDLE && ph_tick && ext_active) begin
            cur_r <= i_req;
        end
    end
    // read byte captured at the end of the strobe slot, memory drives while low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rsp <= '0;
        end else begin
            o_rsp.done <= (state_r == ST_DONE);
            if ((state_r == ST_RDATA || state_r == ST_FETCH) && ph_tick) begin
                o_rsp.rdata <= i_low_address_data_port;
            end
        end
    end
    // ==========================================================
    // strobes, registered so they are glitch free
    logic in_slot_mid;
    assign in_slot_mid = (ph_r != '0) && (ph_r != `STROBE_CNT_W'(`OSC_PER_STROBE - 1));
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_address_latch_strobe <= 1'b0;
            o_program_fetch_strobe_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_write_strobe_n <= 1'b1;
        end else if (dev_reset) begin
            o_address_latch_strobe <= 1'b0;
            o_program_fetch_strobe_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_write_strobe_n <= 1'b1;
        end else begin
            // latch strobe falls mid slot while address still held
            o_address_latch_strobe <= (state_r == ST_ADDR)
                && (ph_r < `STROBE_CNT_W'(`LATCH_PHASES));
            // one fetch pulse per code access, none in data cycles
            o_program_fetch_strobe_n <= !(state_r == ST_FETCH && in_slot_mid);
            // mutually exclusive states keep strobes apart
            o_read_strobe_n <= !(state_r == ST_RDATA && in_slot_mid);
            o_write_strobe_n <= !(state_r == ST_WDATA && in_slot_mid);
        end
    end
    assign o_program_fetch_strobe_n_oe_n = dev_reset || dev_reset_d_r;
    // ==========================================================
    // pad drive
    logic bus_owns;
    assign bus_owns = (state_r != ST_IDLE) && (state_r != ST_DONE);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_low_address_data_port <= 8'hff;
            o_low_address_data_port_oe_n <= 8'hff;
        end else if (state_r == ST_ADDR || (bus_owns && state_nxt == ST_ADDR)) begin
            // address byte, ones driven strongly
            o_low_address_data_port <= cur_r.addr[7:0];
            o_low_address_data_port_oe_n <= 8'h00;
        end else if (state_r == ST_WDATA) begin
            o_low_address_data_port <= cur_r.wdata;
            o_low_address_data_port_oe_n <= 8'h00;
        end else if (bus_owns) begin
            // released so memory can drive it
            o_low_address_data_port <= 8'hff;
            o_low_address_data_port_oe_n <= 8'hff;
        end else begin
            // port mode: open drain, ones float
            o_low_address_data_port <= i_port0_out;
            o_low_address_data_port_oe_n <= i_port0_out;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_high_address_port <= 8'hff;
            o_high_address_port_oe_n <= 8'hff;
        end else if (bus_owns && cur_r.is_data && cur_r.wide) begin
            // page byte on the latch slot, middle byte after
            o_high_address_port <= (state_r == ST_ADDR) ? cur_r.addr[23:16] : cur_r.addr[15:8];
            o_high_address_port_oe_n <= 8'h00;
        end else if (bus_owns) begin
            o_high_address_port <= cur_r.addr[15:8];
            o_high_address_port_oe_n <= 8'h00;
        end else begin
            // ones left to the weak pull-up so the pin reads as input
            o_high_address_port <= i_port2_out;
            o_high_address_port_oe_n <= i_port2_out;
        end
    end
    assign o_high_address_port_pullup = 8'hff;
endmodule

// ==== reset_filter.sv ====
// reset pin qualifier: high for the hold count resets the device
// assumes the pin is synchronous to i_clk
`timescale 1ns/1ps
`include "ext_bus_params.svh"
module reset_filter (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reset_pin,
    output logic o_dev_reset
);
    logic [`RST_CNT_W-1:0] cnt_r;
    // glitches shorter than the hold count never reset the core
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
        end else if (!i_reset_pin) begin
            cnt_r <= '0;
        end else if (cnt_r != `RST_CNT_W'(`RESET_HOLD_CYCLES)) begin
            cnt_r <= cnt_r + `RST_CNT_W'(1);
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dev_reset <= 1'b0;
        end else begin
            o_dev_reset <= i_reset_pin && (cnt_r == `RST_CNT_W'(`RESET_HOLD_CYCLES - 1)
                || cnt_r == `RST_CNT_W'(`RESET_HOLD_CYCLES));
        end
    end
endmodule

// ==== test_external_memory_bus_port.sv ====
// self-checking bench for the external memory bus port
// assumes ext_mem_model on the far side; inputs change on the falling edge
`timescale 1ns/1ps
module test_external_memory_bus_port;
    import ext_bus_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, rpin = 1'b0, sel_n = 1'b1, strap = 1'b1;
    bus_req_t req = '0;
    bus_rsp_t rsp;
    logic [7:0] lo_o, lo_oe, hi_o, hi_oe, hi_pu, lo_bus, hi_bus, m_d, wd;
    logic ci, dvr, dl, fs_o, fs_oe, fs_pin, ale, rd_n, wr_n, m_en;
    logic [23:0] wa;
    int n_fail = 0, cmp_count = 0;
    always #12.5 i_clk = ~i_clk;
    // released low lines show memory data, else the inverse of the port output; released high lines read high
    assign lo_bus = (~lo_oe & lo_o) | (lo_oe & (m_en ? m_d : ~lo_o));
    assign hi_bus = (~hi_oe & hi_o) | hi_oe;
    assign fs_pin = fs_oe ? strap : fs_o;
    external_memory_bus_port DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reset_pin(rpin),
        .i_external_fetch_select_n(sel_n), .i_req(req), .o_rsp(rsp), .o_code_internal(ci),
        .o_dev_reset(dvr), .o_download_mode(dl), .i_port0_out(8'h0f), .i_port2_out(8'h3c),
        .i_low_address_data_port(lo_bus), .o_low_address_data_port(lo_o),
        .o_low_address_data_port_oe_n(lo_oe), .i_high_address_port(hi_bus),
        .o_high_address_port(hi_o), .o_high_address_port_oe_n(hi_oe),
        .o_high_address_port_pullup(hi_pu), .i_program_fetch_strobe_n(fs_pin),
        .o_program_fetch_strobe_n(fs_o), .o_program_fetch_strobe_n_oe_n(fs_oe),
        .o_address_latch_strobe(ale), .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n));
    ext_mem_model u_mem (.i_clk(i_clk), .i_low_bus(lo_bus), .i_high(hi_bus), .i_ale(ale),
        .i_fetch_n(fs_o), .i_rd_n(rd_n), .i_wr_n(wr_n), .o_drive(m_en), .o_data(m_d),
        .o_wr_addr(wa), .o_wr_data(wd));
    // ============================================================
    // shared tasks
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic dev_reset(input logic s, input int n);
        strap = s;
        rpin = 1'b1;
        cyc(n);
        rpin = 1'b0;
        cyc(3);
        strap = 1'b1;
    endtask
    task automatic xfer(input logic d, input logic w, input logic wide, input logic [23:0] a);
        int k;
        req = '{1'b1, d, w, wide, a, 8'ha5};
        for (k = 0; k < 60 && rsp.done !== 1'b1; k++) cyc(1);
        if (k == 60) begin
            chk(24'h0, 24'h1);
            stop_test();
        end
        req.valid = 1'b0;
        cyc(1);
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset();
        rpin = 1'b1;
        cyc(10);
        chk(dvr, 1'b0);
        cyc(20);
        chk(dvr, 1'b1);
        chk(fs_oe, 1'b1);
        rpin = 1'b0;
        cyc(3);
        chk(dl, 1'b0);
        dev_reset(1'b0, 26);
        chk(dl, 1'b1);
        dev_reset(1'b1, 26);
        chk(dl, 1'b0);
    endtask
    task automatic t_idle();
        chk(lo_oe, 8'h0f);
        chk(lo_o & ~lo_oe, 8'h00);
        chk(hi_pu, 8'hff);
        chk(hi_bus, 8'h3c);
        chk(fs_oe, 1'b0);
    endtask
    task automatic t_data();
        xfer(1'b1, 1'b1, 1'b1, 24'h123456);
        chk(wa, 24'h123456);
        chk(wd, 8'ha5);
        xfer(1'b1, 1'b0, 1'b1, 24'h7e80ff);
        chk(rsp.rdata, 8'hff ^ 8'h80 ^ 8'h5a);
    endtask
    task automatic t_code();
        sel_n = 1'b0;
        xfer(1'b0, 1'b0, 1'b0, 24'h001234);
        chk(rsp.rdata, 8'h34 ^ 8'h12 ^ 8'h5a);
        sel_n = 1'b1;
        req = '{1'b1, 1'b0, 1'b0, 1'b0, 24'h001fff, 8'h00};
        repeat (12) begin
            cyc(1);
            chk({ci, fs_o, rsp.done}, 3'b110);
        end
        req.valid = 1'b0;
        cyc(1);
        xfer(1'b0, 1'b0, 1'b0, 24'h002000);
        chk(rsp.rdata, 8'h00 ^ 8'h20 ^ 8'h5a);
    endtask
    initial begin
        cyc(6);
        i_rst_n = 1'b1;
        cyc(2);
        t_reset();
        t_idle();
        t_data();
        t_code();
        stop_test();
    end
endmodule
